/* File: common/pad_defines.svh */
// constants for the programmable address decoder
`ifndef PAD_DEFINES_SVH
`define PAD_DEFINES_SVH

`define PAD_DEC_W        12
`define PAD_DEC_HA_LSB   0
`define PAD_DEC_HA_W     5
`define PAD_DEC_PC_LSB   5
`define PAD_DEC_PC_W     3
`define PAD_DEC_EXTRA    8
`define PAD_DEC_RD       9
`define PAD_DEC_WR       10
`define PAD_DEC_ALE      11
`define PAD_DEC_PC_MASK  12'h0e0

`define PAD_BANKS        8
`define PAD_A_TERMS      9
`define PAD_A_PORT_TERM  8
`define PAD_B_TERMS      27
`define PAD_NUM_CS       11
`define PAD_PB_CS        8
`define PAD_BYTE_W       8

`define PAD_CS_IDLE_N    11'h7ff
`define PAD_BANK_IDLE    8'h00
`define PAD_BYTE_RST     8'h00
`define PAD_PC_RST       3'h0

`endif

/* File: common/pad_if.sv */
// decoder inputs and product-term results between top and an array
`timescale 1ns/1ps
`include "pad_defines.svh"
interface pad_if #(
    parameter int N_TERMS = `PAD_A_TERMS
);
    logic [`PAD_DEC_W-1:0] dec_in;
    logic [N_TERMS-1:0]    term;

    modport src (output dec_in, input term);
    modport arr (input dec_in, output term);
endinterface

/* File: common/pad_pkg.sv */
// types shared by the programmable address decoder
package pad_pkg;
    typedef enum logic {
        PAD_PCIN_ADDR,
        PAD_PCIN_LOGIC
    } pad_pcin_e;

    typedef enum logic {
        PAD_BUS_RD_WR,
        PAD_BUS_E_RW
    } pad_bus_e;
endpackage

/* File: rtl/pad_array.sv */
// one product-term array: each term ands chosen true or inverted inputs
`timescale 1ns/1ps
`include "pad_defines.svh"
module pad_array
    import pad_pkg::*;
#(
    parameter int                             N_TERMS = `PAD_A_TERMS,
    parameter logic [N_TERMS*`PAD_DEC_W-1:0]  P_USE   = '0,
    parameter logic [N_TERMS*`PAD_DEC_W-1:0]  P_POL   = '0,
    parameter logic [N_TERMS-1:0]             P_EN    = '0
) (
    pad_if.arr bus  // inputs in, terms out
);
    genvar t;
    generate
        for (t = 0; t < N_TERMS; t++) begin : g_term
            localparam logic [`PAD_DEC_W-1:0] USE =
                P_USE[t*`PAD_DEC_W +: `PAD_DEC_W];
            localparam logic [`PAD_DEC_W-1:0] POL =
                P_POL[t*`PAD_DEC_W +: `PAD_DEC_W];
            // pol bit set means the literal is complemented
            assign bus.term[t] = P_EN[t] &
                (&((bus.dec_in ^ POL) | ~USE));
        end
    endgenerate
endmodule

/* File: rtl/pad_top.sv */
// bus front end and two-array programmable address decoder
`timescale 1ns/1ps
`include "pad_defines.svh"
module pad_top
    import pad_pkg::*;
#(
    parameter logic                   P_ALE_HIGH    = 1'b1,
    parameter pad_bus_e               P_BUS_MODE    = PAD_BUS_RD_WR,
    parameter logic                   P_CSI_MODE    = 1'b1,
    parameter logic                   P_A19_LATCH   = 1'b1,
    parameter pad_pcin_e              P_PCIN        = PAD_PCIN_ADDR,
    parameter logic                   P_PC_LATCH    = 1'b1,
    parameter logic [2:0]             P_PC_OUT      = 3'h0,
    parameter logic [7:0]             P_PA_ADDR     = 8'h00,
    parameter logic [7:0]             P_PB_CS       = 8'h00,
    parameter logic [`PAD_A_TERMS*`PAD_DEC_W-1:0] P_A_USE = '0,
    parameter logic [`PAD_A_TERMS*`PAD_DEC_W-1:0] P_A_POL = '0,
    parameter logic [`PAD_A_TERMS-1:0]            P_A_EN  = '0,
    parameter logic [`PAD_B_TERMS*`PAD_DEC_W-1:0] P_B_USE = '0,
    parameter logic [`PAD_B_TERMS*`PAD_DEC_W-1:0] P_B_POL = '0,
    parameter logic [`PAD_B_TERMS-1:0]            P_B_EN  = '0
) (
    input  wire logic        i_clk,                  // 40 MHz
    input  wire logic        i_rstn,                 // async, low
    input  wire logic        i_address_latch_strobe, // ale or as
    input  wire logic [7:0]  i_muxed_addr_data,      // low bus in
    output logic      [7:0]  o_muxed_addr_data,      // low bus out
    output logic             o_muxed_addr_data_oe,   // bus drive
    input  wire logic [4:0]  i_high_address,         // addr 15..11
    input  wire logic        i_read_strobe,          // rd_n or e
    input  wire logic        i_write_ctl,            // wr_n or r/w
    input  wire logic        i_select_or_extra_input,// csi or a19
    input  wire logic [2:0]  i_port_c_pins,          // port c in
    output logic      [2:0]  o_port_c_pins,          // port c out
    output logic      [2:0]  o_port_c_oe,            // port c drive
    input  wire logic [7:0]  i_pa_io_out,            // port a io data
    input  wire logic [7:0]  i_pa_io_oe,             // port a io dir
    output logic      [7:0]  o_pa_out,               // port a out
    output logic      [7:0]  o_pa_oe,                // port a drive
    input  wire logic [7:0]  i_pb_io_out,            // port b io data
    input  wire logic [7:0]  i_pb_io_oe,             // port b io dir
    output logic      [7:0]  o_pb_out,               // port b out
    output logic      [7:0]  o_pb_oe,                // port b drive
    input  wire logic [7:0]  i_rd_data,              // internal read
    output logic      [7:0]  o_wr_data,              // write byte
    output logic             o_wr_strobe,            // write done
    output logic [7:0]       o_memory_bank_selects,  // banks, high
    output logic             o_port_register_select, // ports, high
    output logic             o_power_down            // standby
);
    // logic-mode port c bits never reach the internal array
    localparam logic [`PAD_A_TERMS*`PAD_DEC_W-1:0] A_USE_EFF =
        (P_PCIN == PAD_PCIN_LOGIC) ?
        (P_A_USE & ~{`PAD_A_TERMS{`PAD_DEC_PC_MASK}}) : P_A_USE;

    logic                  ale_act;
    logic                  ale_act_r;
    logic                  ale_end;
    logic [7:0]            addr_lat_r;
    logic [2:0]            pc_lat_r;
    logic                  a19_lat_r;
    logic [2:0]            pc_dec;
    logic                  extra_dec;
    logic                  pd;
    logic [`PAD_DEC_W-1:0] dec_in;
    logic                  read_act;
    logic                  write_act;
    logic                  write_act_r;
    logic                  sel_any_nxt;
    logic                  sel_any_r;
    logic [`PAD_NUM_CS-1:0] cs_act;
    logic [`PAD_NUM_CS-1:0] cs_n_nxt;
    logic [`PAD_NUM_CS-1:0] cs_n_r;
    logic                  chk_arm_r;

    pad_if #(.N_TERMS(`PAD_A_TERMS)) u_if_a ();
    pad_if #(.N_TERMS(`PAD_B_TERMS)) u_if_b ();

    // strobe front end
    assign ale_act = P_ALE_HIGH ? i_address_latch_strobe
                                : ~i_address_latch_strobe;
    assign ale_end = ale_act_r & ~ale_act;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ale_act_r <= 1'b0;
        end else begin
            ale_act_r <= ale_act;
        end
    end

    // latches follow the bus while the strobe is active, so the value
    // held after the trailing edge is the last one seen in the window
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            addr_lat_r <= `PAD_BYTE_RST;
            pc_lat_r   <= `PAD_PC_RST;
            a19_lat_r  <= 1'b0;
        end else if (ale_act) begin
            addr_lat_r <= i_muxed_addr_data;
            pc_lat_r   <= i_port_c_pins;
            a19_lat_r  <= i_select_or_extra_input;
        end
    end

    // decoder inputs
    assign pc_dec = (P_PC_LATCH ? pc_lat_r : i_port_c_pins)
                    & ~P_PC_OUT;
    assign extra_dec = P_CSI_MODE ? 1'b0 :
        (P_A19_LATCH ? a19_lat_r : i_select_or_extra_input);
    assign pd = P_CSI_MODE & i_select_or_extra_input;

    always_comb begin
        dec_in = '0;
        dec_in[`PAD_DEC_HA_LSB +: `PAD_DEC_HA_W] = i_high_address;
        dec_in[`PAD_DEC_PC_LSB +: `PAD_DEC_PC_W] = pc_dec;
        dec_in[`PAD_DEC_EXTRA] = extra_dec;
        // reset is deliberately absent from the input vector
        dec_in[`PAD_DEC_RD]  = i_read_strobe;
        dec_in[`PAD_DEC_WR]  = i_write_ctl;
        dec_in[`PAD_DEC_ALE] = i_address_latch_strobe;
    end

    assign u_if_a.dec_in = dec_in;
    assign u_if_b.dec_in = dec_in;

    pad_array #(
        .N_TERMS (`PAD_A_TERMS),
        .P_USE   (A_USE_EFF),
        .P_POL   (P_A_POL),
        .P_EN    (P_A_EN)
    ) u_pad_a (
        .bus (u_if_a.arr)
    );

    pad_array #(
        .N_TERMS (`PAD_B_TERMS),
        .P_USE   (P_B_USE),
        .P_POL   (P_B_POL),
        .P_EN    (P_B_EN)
    ) u_pad_b (
        .bus (u_if_b.arr)
    );

    // external select groups: 4, 2 and 1 terms per select
    genvar c;
    generate
        for (c = 0; c < `PAD_NUM_CS; c++) begin : g_cs
            localparam int CNT  = (c < 4) ? 4 : ((c < 8) ? 2 : 1);
            localparam int BASE = (c < 4) ? 4 * c :
                                  ((c < 8) ? 16 + 2 * (c - 4)
                                           : 24 + (c - 8));
            assign cs_act[c] = |u_if_b.term[BASE +: CNT];
        end
    endgenerate

    assign cs_n_nxt = ~(cs_act & {`PAD_NUM_CS{~pd}});

    // decoder outputs, one register stage
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cs_n_r                 <= `PAD_CS_IDLE_N;
            o_memory_bank_selects  <= `PAD_BANK_IDLE;
            o_port_register_select <= 1'b0;
            o_power_down           <= 1'b0;
        end else begin
            cs_n_r <= cs_n_nxt;
            o_memory_bank_selects <= pd ? `PAD_BANK_IDLE :
                u_if_a.term[`PAD_BANKS-1:0];
            o_port_register_select <= ~pd &
                u_if_a.term[`PAD_A_PORT_TERM];
            o_power_down <= pd;
        end
    end

    // port pins: routing set at build time
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_pa_out      <= `PAD_BYTE_RST;
            o_pa_oe       <= `PAD_BYTE_RST;
            o_pb_out      <= `PAD_BYTE_RST;
            o_pb_oe       <= `PAD_BYTE_RST;
            o_port_c_pins <= `PAD_PC_RST;
            o_port_c_oe   <= `PAD_PC_RST;
        end else begin
            o_pa_out <= (addr_lat_r & P_PA_ADDR)
                      | (i_pa_io_out & ~P_PA_ADDR);
            o_pa_oe  <= P_PA_ADDR | i_pa_io_oe;
            o_pb_out <= (cs_n_nxt[`PAD_PB_CS-1:0] & P_PB_CS)
                      | (i_pb_io_out & ~P_PB_CS);
            o_pb_oe  <= P_PB_CS | i_pb_io_oe;
            o_port_c_pins <= cs_n_nxt[`PAD_NUM_CS-1:`PAD_PB_CS]
                           & P_PC_OUT;
            o_port_c_oe   <= P_PC_OUT;
        end
    end

    // data phase; e mode pairs the e clock with r/w high for reads
    assign read_act  = (P_BUS_MODE == PAD_BUS_E_RW) ?
        (i_read_strobe & i_write_ctl) : ~i_read_strobe;
    assign write_act = (P_BUS_MODE == PAD_BUS_E_RW) ?
        (i_read_strobe & ~i_write_ctl) : ~i_write_ctl;
    assign sel_any_nxt = ~pd & (|u_if_a.term);

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_muxed_addr_data    <= `PAD_BYTE_RST;
            o_muxed_addr_data_oe <= 1'b0;
        end else begin
            // never drive while the address is on the pins
            o_muxed_addr_data_oe <= read_act & sel_any_nxt
                                  & ~ale_act;
            o_muxed_addr_data    <= i_rd_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            write_act_r <= 1'b0;
            sel_any_r   <= 1'b0;
            o_wr_data   <= `PAD_BYTE_RST;
            o_wr_strobe <= 1'b0;
        end else begin
            write_act_r <= write_act;
            sel_any_r   <= sel_any_nxt;
            if (write_act) begin
                o_wr_data <= i_muxed_addr_data;
            end
            // strobe at the end of the pulse, data is then complete
            o_wr_strobe <= write_act_r & ~write_act & sel_any_r;
        end
    end

    // checks; the release edge still resets the flops, so skip it
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            chk_arm_r <= 1'b0;
        end else begin
            chk_arm_r <= 1'b1;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn || !chk_arm_r);

    sequence s_strobe_end;
        ale_act_r && !ale_act;
    endsequence

    sequence s_read_sel;
        read_act && sel_any_nxt && !ale_act;
    endsequence

    a_addr_capture: assert property (
        s_strobe_end |-> addr_lat_r == $past(i_muxed_addr_data)
                         ##1 addr_lat_r == $past(addr_lat_r))
        else $error("address latch did not hold captured byte");

    a_read_drive: assert property (
        s_read_sel |=> o_muxed_addr_data_oe
                       && o_muxed_addr_data == $past(i_rd_data))
        else $error("read data not driven");

    a_no_drive_ale: assert property (
        ale_act |=> !o_muxed_addr_data_oe)
        else $error("bus driven during address phase");

    a_pa_address: assert property (
        ##1 ((o_pa_out & P_PA_ADDR) == ($past(addr_lat_r) & P_PA_ADDR)))
        else $error("port a address bits wrong");

    a_power_down: assert property (
        pd |=> o_memory_bank_selects == `PAD_BANK_IDLE
               && !o_port_register_select && &cs_n_r && o_power_down)
        else $error("outputs active in power down");

    a_cs_four: assert property (
        ##1 (cs_n_r[0] == !($past(|u_if_b.term[3:0]) && !$past(pd))))
        else $error("select 0 not or of four terms");

    a_cs_two: assert property (
        ##1 (cs_n_r[4] == !($past(|u_if_b.term[17:16]) && !$past(pd))))
        else $error("select 4 not or of two terms");

    a_cs_one: assert property (
        ##1 (cs_n_r[10] == !($past(u_if_b.term[26]) && !$past(pd))))
        else $error("select 10 not its single term");

    a_bank_term: assert property (
        !pd |=> o_memory_bank_selects == $past(u_if_a.term[7:0]))
        else $error("bank selects differ from terms");

    a_port_sel: assert property (
        ##1 (o_port_register_select ==
             ($past(u_if_a.term[8]) && !$past(pd))))
        else $error("port register select wrong");

    a_pc_share: assert property (
        ##1 (o_port_c_oe == P_PC_OUT && (o_port_c_pins & ~P_PC_OUT) == 0))
        else $error("port c pin shared wrongly");

    a_reset_idle: assert property (@(posedge i_clk) disable iff (1'b0)
        !i_rstn |-> &cs_n_r && o_memory_bank_selects == 0
                    && !o_port_register_select)
        else $error("outputs active in reset");
endmodule

/* File: testbench/pad_mcu_model.sv */
// multiplexed-bus host model driving the decoder's bus pins
`timescale 1ns/1ps
module pad_mcu_model (
    input  wire logic       i_clk,  // host clock
    output logic            o_ale,  // address strobe, high
    output logic      [7:0] o_ad,   // low bus drive
    output logic      [4:0] o_ha,   // address 15..11
    output logic            o_rd_n, // read, low
    output logic            o_wr_n, // write, low
    output logic      [2:0] o_pc    // port c levels
);
    initial begin
        {o_ale, o_ad, o_ha, o_pc} = '0;
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
    end

    task automatic addr_phase(input logic [15:0] a, input logic [2:0] pc);
        @(posedge i_clk);
        o_ale <= 1'b1;
        o_ad  <= a[7:0];
        o_ha  <= a[15:11];
        o_pc  <= pc;
        repeat (2) @(posedge i_clk);
        o_ale <= 1'b0;
        // released lines flip so a stale latch cannot pass
        o_ad  <= ~a[7:0];
        o_pc  <= ~pc;
        repeat (4) @(posedge i_clk);
    endtask

    task automatic rd_level(input logic lvl);
        @(posedge i_clk);
        o_rd_n <= lvl;
    endtask

    task automatic wr_cycle(input logic [7:0] d);
        @(posedge i_clk);
        o_wr_n <= 1'b0;
        o_ad   <= d;
        repeat (2) @(posedge i_clk);
        o_wr_n <= 1'b1;
        @(posedge i_clk);
        o_ad   <= ~d;
        repeat (4) @(posedge i_clk);
    endtask
endmodule

/* File: testbench/test_programmable_address_decoder.sv */
// self-checking bench for the programmable address decoder
`timescale 1ns/1ps
`include "pad_defines.svh"
module test_programmable_address_decoder;
    import pad_pkg::*;
    localparam int PW = `PAD_DEC_W;
    typedef struct {
        int kind; logic [7:0] banks; logic psel; logic [7:0] pb;
        logic [2:0] pc; logic pd; logic [7:0] pa; logic [7:0] paoe;
        logic oe; logic [7:0] rdat; int wcnt; logic [7:0] wdat;
    } pad_exp_s;

    // banks match A15..11 == t, port registers at 5'h1f
    function automatic logic [`PAD_A_TERMS*PW-1:0] a_cfg(input bit pol);
        logic [`PAD_A_TERMS*PW-1:0] v;
        v = '0;
        for (int t = 0; t < `PAD_A_TERMS; t++) begin
            v[t*PW+:PW] = pol ? {7'h00, ~((t < 8) ? 5'(t) : 5'h1f)} : 12'h01f;
        end
        return v;
    endfunction

    // selects 0..7 hit at 8+c or 24+c; select 10 only at 8+c with port c bit 0; selects 8, 9 never hit
    function automatic logic [`PAD_B_TERMS*PW-1:0] b_cfg(input bit pol);
        logic [`PAD_B_TERMS*PW-1:0] v;
        int f;
        v = '0;
        for (int c = 0; c < 8; c++) begin
            f = (c < 4) ? 4*c : 16+2*(c-4);
            v[f*PW+:PW] = pol ? {7'h00, ~5'(8+c)} : 12'h01f;
            v[(f+1)*PW+:PW] = pol ? {7'h00, ~5'(24+c)} : 12'h01f;
        end
        v[26*PW+:PW] = pol ? {7'h00, ~5'h12} : 12'h03f;
        return v;
    endfunction

    localparam logic [`PAD_A_TERMS*PW-1:0] A_USE = a_cfg(0);
    localparam logic [`PAD_A_TERMS*PW-1:0] A_POL = a_cfg(1);
    localparam logic [`PAD_B_TERMS*PW-1:0] B_USE = b_cfg(0);
    localparam logic [`PAD_B_TERMS*PW-1:0] B_POL = b_cfg(1);
    localparam logic [`PAD_A_TERMS-1:0]    A_EN  = 9'h1ff;
    localparam logic [`PAD_B_TERMS-1:0]    B_EN  = 27'h4ff3333;

    logic i_clk, i_rstn, ale, rd_n, wr_n, csi, oe, wstb, pd, psel;
    logic [7:0] mcu_ad, dout, pa_io_out, pa_io_oe, pb_io_out, pb_io_oe;
    logic [7:0] rd_data, pa_out, pa_oe, pb_out, pb_oe, wr_data, banks;
    logic [4:0] ha;
    logic [2:0] pc_in, pc_out, pc_oe;
    wire  [7:0] ad_wire = oe ? dout : mcu_ad;
    int n_fail, cmp_count, n_wstb;
    pad_exp_s q[$];
    event chk;

    pad_mcu_model i_mcu (.i_clk(i_clk), .o_ale(ale), .o_ad(mcu_ad),
        .o_ha(ha), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_pc(pc_in));

    pad_top #(.P_PC_OUT(3'h4), .P_PA_ADDR(8'h0f), .P_PB_CS(8'hff),
        .P_A_USE(A_USE), .P_A_POL(A_POL), .P_A_EN(A_EN),
        .P_B_USE(B_USE), .P_B_POL(B_POL), .P_B_EN(B_EN)
    ) i_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_address_latch_strobe(ale),
        .i_muxed_addr_data(ad_wire), .o_muxed_addr_data(dout),
        .o_muxed_addr_data_oe(oe), .i_high_address(ha),
        .i_read_strobe(rd_n), .i_write_ctl(wr_n),
        .i_select_or_extra_input(csi), .i_port_c_pins(pc_in),
        .o_port_c_pins(pc_out), .o_port_c_oe(pc_oe),
        .i_pa_io_out(pa_io_out), .i_pa_io_oe(pa_io_oe), .o_pa_out(pa_out),
        .o_pa_oe(pa_oe), .i_pb_io_out(pb_io_out), .i_pb_io_oe(pb_io_oe),
        .o_pb_out(pb_out), .o_pb_oe(pb_oe), .i_rd_data(rd_data),
        .o_wr_data(wr_data), .o_wr_strobe(wstb),
        .o_memory_bank_selects(banks), .o_port_register_select(psel),
        .o_power_down(pd));

    initial i_clk = 1'b0;
    always #12.5 i_clk = ~i_clk;
    always @(posedge i_clk) if (wstb === 1'b1) n_wstb++;

    task automatic check(input logic [7:0] s, e, input string m);
        cmp_count++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %0t %s seen %h want %h", $time, m, s, e);
        end
    endtask

    task automatic stop_test;
        $display("fails %0d compares %0d", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    function automatic pad_exp_s dec_exp(input logic [4:0] a,
        input logic pc0, input logic cs_hi, input logic [7:0] lat);
        pad_exp_s e;
        e = '{default: 0};
        for (int c = 0; c < 8; c++) begin
            e.banks[c] = !cs_hi && a == 5'(c);
            e.pb[c] = !(!cs_hi && (a == 5'(8+c) || a == 5'(24+c)));
        end
        e.psel = !cs_hi && a == 5'h1f;
        e.pc = {!(!cs_hi && a == 5'h12 && pc0), 2'b00};
        e.pd = cs_hi;
        e.pa = {pa_io_out[7:4], lat[3:0]};
        e.paoe = {pa_io_oe[7:4], 4'hf};
        return e;
    endfunction

    function automatic pad_exp_s bus_exp(input int k, input logic o,
        input logic [7:0] r, input int w, input logic [7:0] d);
        pad_exp_s e;
        e = '{default: 0};
        e.kind = k; e.oe = o; e.rdat = r; e.wcnt = w; e.wdat = d;
        return e;
    endfunction

    task automatic expect_now(input pad_exp_s e);
        q.push_back(e);
        @(negedge i_clk);
        ->chk;
    endtask

    always begin
        pad_exp_s e;
        @(chk);
        e = q.pop_front();
        check(8'(oe), 8'(e.oe), "bus drive");
        if (e.kind == 0) begin
            check(banks, e.banks, "banks");
            check(8'(psel), 8'(e.psel), "port sel");
            check(pb_out, e.pb, "port b");
            check(pb_oe, 8'hff, "port b oe");
            check(8'(pc_out), 8'(e.pc), "port c");
            check(8'(pc_oe), 8'h04, "port c oe");
            check(8'(pd), 8'(e.pd), "standby");
            check(pa_out, e.pa, "port a");
            check(pa_oe, e.paoe, "port a oe");
        end else if (e.kind == 1) begin
            if (e.oe) check(dout, e.rdat, "read data");
            check(8'(n_wstb), 8'(e.wcnt), "write pulses");
            if (e.wcnt > 0) check(wr_data, e.wdat, "write data");
        end else begin
            check(banks, 8'h00, "reset banks");
            check(8'(psel), 8'h00, "reset port sel");
            check(pb_oe, 8'h00, "reset port b oe");
            check(8'(pc_oe), 8'h00, "reset port c oe");
        end
    end

    initial begin
        repeat (5000) @(posedge i_clk);
        n_fail++;
        stop_test();
    end

    initial begin
        logic [7:0] lo;
        logic [2:0] pc;
        void'($urandom(57907));
        // a clean falling edge, so the flops see reset before any clock
        i_rstn = 1'b1;
        #1;
        {i_rstn, csi, rd_data} = '0;
        {pa_io_out, pa_io_oe, pb_io_out, pb_io_oe} = '0;
        repeat (3) @(posedge i_clk);
        expect_now(bus_exp(2, 0, 0, 0, 0));
        @(posedge i_clk);
        i_rstn <= 1'b1;
        for (int a = 0; a < 32; a++) begin
            lo = 8'($urandom);
            pc = 3'($urandom);
            {pa_io_out, pa_io_oe, pb_io_out, pb_io_oe} <= 32'($urandom);
            csi <= ($urandom_range(3) == 0);
            i_mcu.addr_phase({5'(a), 3'($urandom), lo}, pc);
            expect_now(dec_exp(5'(a), pc[0], csi, lo));
        end
        csi = 1'b1;
        i_mcu.addr_phase(16'h1834, 3'h1);
        expect_now(dec_exp(5'h03, 1'b1, 1'b1, 8'h34));
        csi = 1'b0;
        i_mcu.addr_phase(16'h9077, 3'h1);
        expect_now(dec_exp(5'h12, 1'b1, 1'b0, 8'h77));
        i_mcu.rd_level(1'b0);
        repeat (2) @(posedge i_clk);
        expect_now(bus_exp(1, 0, 0, 0, 0));
        i_mcu.rd_level(1'b1);
        i_mcu.addr_phase(16'h2855, 3'h0);
        rd_data <= 8'($urandom);
        i_mcu.rd_level(1'b0);
        repeat (2) @(posedge i_clk);
        expect_now(bus_exp(1, 1, rd_data, 0, 0));
        i_mcu.rd_level(1'b1);
        repeat (3) @(posedge i_clk);
        expect_now(bus_exp(1, 0, 0, 0, 0));
        i_mcu.addr_phase(16'h5000, 3'h0);
        i_mcu.wr_cycle(8'h3c);
        i_mcu.addr_phase(16'h1011, 3'h0);
        i_mcu.wr_cycle(8'ha5);
        expect_now(bus_exp(1, 0, 0, 1, 8'ha5));
        i_mcu.addr_phase(16'h0899, 3'h0);
        i_rstn <= 1'b0;
        repeat (2) @(posedge i_clk);
        expect_now(bus_exp(2, 0, 0, 0, 0));
        @(posedge i_clk);
        i_rstn <= 1'b1;
        i_mcu.addr_phase(16'h0899, 3'h0);
        expect_now(dec_exp(5'h01, 1'b0, 1'b0, 8'h99));
        repeat (2) @(posedge i_clk);
        stop_test();
    end
endmodule
